// >>> core/hswt_fifo.sv
// Synchronous valid/ready FIFO held in flip-flops
`default_nettype none

module hswt_fifo #(
  parameter int WIDTH = 8,                 // Word width
  parameter int DEPTH = 4                  // Entries, a power of two
) (
  input  wire logic             clock,     // FIFO clock
  input  wire logic             reset,     // Asynchronous reset, active high
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Drain accepts
  output logic      [WIDTH-1:0] out_data   // Oldest word
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0]      wr_ptr_ff;
  logic [PW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_ff[PW-1:0] != rd_ptr_ff[PW-1:0]) || (wr_ptr_ff[PW] == rd_ptr_ff[PW]);
  assign out_valid = (wr_ptr_ff != rd_ptr_ff);
  assign out_data  = mem_ff[rd_ptr_ff[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + (PW+1)'(1);
      if (pop)  rd_ptr_ff <= rd_ptr_ff + (PW+1)'(1);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem_ff[wr_ptr_ff[PW-1:0]] <= in_data;
  end

endmodule // hswt_fifo

`default_nettype wire

// >>> core/hswt_pkg.sv
// Package: constants and carrier types for the host serial word port
`default_nettype none

package hswt_pkg;

  // Word framing
  localparam int          WORD_W          = 16;            // Every transfer is one 16-bit word
  localparam int          ADDR_W          = 15;            // Register address width
  localparam int          DIR_BIT         = 15;            // Direction bit position in the instruction
  localparam int          CNT_W           = 4;             // Bit counter width
  localparam logic [3:0]  LAST_BIT        = 4'hf;          // Counter value of a word's last bit
  localparam logic [3:0]  FIRST_BIT       = 4'h0;          // Counter value of a word's first bit
  localparam logic        DIR_READ        = 1'b1;          // Direction value for a read
  localparam logic        DIR_WRITE       = 1'b0;          // Direction value for a write
  localparam int          FIRST_DATA_SCLK = 33;            // Serial clock that carries the first read bit

  // Reset values
  localparam logic [14:0] ADDR_RST        = 15'h0000;      // Address register after reset
  localparam logic [15:0] WORD_RST        = 16'h0000;      // Any data word after reset
  localparam logic [15:0] REMAIN_ONE      = 16'h0001;      // One word left to return

  // Buffering and timing
  localparam int          FIFO_DEPTH      = 4;             // Write words buffered toward the user
  localparam int          SYNC_STAGES     = 2;             // Flops in each synchroniser
  localparam int          CLK_PERIOD_PS   = 5000;          // System clock period, 200 MHz
  localparam int          SCLK_MIN_PS     = 62500;         // Fastest serial clock period, 16 MHz
  localparam int          SCLK_IN_CLK     = SCLK_MIN_PS / CLK_PERIOD_PS; // System cycles per serial bit, rounded down

  // Frame phase in the serial clock domain
  typedef enum logic [2:0] {
    PH_INSTR,
    PH_COUNT,
    PH_WDATA,
    PH_RDATA,
    PH_DONE
  } hswt_phase_type;

  // User-side read handshake
  typedef enum logic {
    RD_IDLE,
    RD_WAIT
  } hswt_rd_state_type;

  // One write: register address and data word
  typedef struct packed {
    logic [14:0] addr;
    logic [15:0] data;
  } hswt_wr_word_type;

  localparam int WR_WORD_W = $bits(hswt_wr_word_type);   // Carrier width through the FIFO

endpackage

`default_nettype wire

// >>> core/hswt_sync.sv
// Two-flop level synchroniser, one lane per bit
`default_nettype none

module hswt_sync #(
  parameter int WIDTH = 1                  // Number of independent lanes
) (
  input  wire logic             clk,       // Destination clock
  input  wire logic             rst,       // Asynchronous reset, active high
  input  wire logic [WIDTH-1:0] d,         // Level from the other domain
  output logic      [WIDTH-1:0] q          // Level in this domain
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule // hswt_sync

`default_nettype wire

// >>> core/hswt_top.sv
// Serial word port: instruction, count and data framing with user-side register access
// Operation
// - First word: direction bit, 15-bit address
// - Read: second word gives word count
// - Count zero or one returns one word
// - Read data starts on serial clock 33
// - Direction zero means register write
// - Write data follows instruction, no count
// - Further write words go to next address
// - Sample on rising, drive on falling
// - Select falling starts each transaction
// - Address steps up, or down if chosen
// - MSB first, or LSB first if chosen
`default_nettype none

module hswt_top
  import hswt_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH               // Write buffer depth
) (
  input  wire logic                     clock,          // System clock
  input  wire logic                     reset,          // Asynchronous reset, active high
  input  wire logic                     sclk,           // Serial shift clock from the host
  input  wire logic                     cs_n,           // Chip select, active low
  input  wire logic                     serial_data_in, // Data from the host
  input  wire logic                     lsb_first,      // Shift least significant bit first
  input  wire logic                     addr_decrement, // Step the address downward
  output logic                          serial_data_out,     // Data to the host
  output logic                          serial_data_out_en,  // High while the port drives data
  output logic                          wr_valid,       // Write word offered to the user
  input  wire logic                     wr_ready,       // User takes the write word
  output hswt_pkg::hswt_wr_word_type    wr_word,        // Write address and data
  output logic                          rd_req,         // Read request to the user
  output logic                   [14:0] rd_addr,        // Read address
  input  wire logic                     rd_valid,       // Read data present
  input  wire logic              [15:0] rd_data,        // Read data
  output logic                          wr_overflow     // A write word was lost in this frame
);

  import hswt_pkg::*;

  // Serial domain state
  logic             link_rst;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic [15:0]      shift_ff;
  logic [15:0]      nxt_shift;
  logic [15:0]      raw_word;
  logic             word_done;
  hswt_phase_type   phase_ff;
  logic [14:0]      addr_ff;
  logic [15:0]      remain_ff;
  logic             rreq_tog_ff;
  logic [14:0]      rreq_addr_ff;
  logic             wreq_tog_ff;
  hswt_wr_word_type wreq_word_ff;
  logic             ovf_ff;
  logic [15:0]      tx_shift_ff;
  logic             sdo_ff;
  logic             sdo_en_ff;
  logic [3:0]       link_sync;
  logic             lsb_s;
  logic             dec_s;
  logic             rack_s;
  logic             wack_s;
  logic             rd_ready_s;
  logic             wr_pend_s;
  logic             post_first;
  logic             post_next;

  // System domain state
  logic [2:0]        sys_sync;
  logic              rreq_s;
  logic              wreq_s;
  hswt_rd_state_type rd_state_ff;
  logic              rack_tog_ff;
  logic              wack_tog_ff;
  logic [15:0]       rdata_hold_ff;
  logic              rd_req_ff;
  logic [14:0]       rd_addr_ff;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WR_WORD_W-1:0] fifo_out_data;
  logic              wr_valid_ff;
  hswt_wr_word_type  wr_word_ff;

  // Next stream address, either direction
  function automatic logic [14:0] step_addr(input logic [14:0] a, input logic dec);
    return dec ? a - 15'h0001 : a + 15'h0001;
  endfunction

  // Mirror a word for least significant bit first order
  function automatic logic [15:0] bit_rev(input logic [15:0] w);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = w[15 - i];
    return r;
  endfunction

  // Select high holds the serial bit counter, phase and output shifter in reset
  assign link_rst = reset | cs_n;

  // ---------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------

  // Config pins and acknowledge toggles into the serial domain
  hswt_sync #(
    .WIDTH (4)
  ) u_link_sync (
    .clk (sclk),
    .rst (reset),
    .d   ({lsb_first, addr_decrement, rack_tog_ff, wack_tog_ff}),
    .q   (link_sync)
  );

  assign lsb_s  = link_sync[3];
  assign dec_s  = link_sync[2];
  assign rack_s = link_sync[1];
  assign wack_s = link_sync[0];

  // Handshake status as seen by the serial side
  assign rd_ready_s = (rreq_tog_ff == rack_s);
  assign wr_pend_s  = (wreq_tog_ff != wack_s);

  // Bits enter at the bottom; order applies only to a whole word,
  // as the synchronised order pin settles two serial edges into a frame
  assign raw_word  = {shift_ff[14:0], serial_data_in};
  assign nxt_shift = lsb_s ? bit_rev(raw_word) : raw_word;

  assign word_done = (bit_cnt_ff == LAST_BIT);

  // Bit counter and shifter, sampled on the rising edge
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_ff <= '0;
      shift_ff   <= WORD_RST;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff   <= raw_word;
    end
  end

  // Frame phase, address and remaining read count
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      phase_ff  <= PH_INSTR;
      addr_ff   <= ADDR_RST;
      remain_ff <= WORD_RST;
    end else if (word_done) begin
      case (phase_ff)
        PH_INSTR: begin
          addr_ff <= nxt_shift[ADDR_W-1:0];
          if (nxt_shift[DIR_BIT] == DIR_READ) begin
            phase_ff <= PH_COUNT;
          end else begin
            phase_ff <= PH_WDATA;
          end
        end
        PH_COUNT: begin
          // Zero and one both mean a single word
          remain_ff <= (nxt_shift == WORD_RST) ? REMAIN_ONE : nxt_shift;
          phase_ff  <= PH_RDATA;
        end
        PH_WDATA: begin
          addr_ff <= step_addr(addr_ff, dec_s);
        end
        PH_RDATA: begin
          addr_ff   <= step_addr(addr_ff, dec_s);
          remain_ff <= remain_ff - 16'h0001;
          // Host keeps select low until the last word
          if (remain_ff == REMAIN_ONE) phase_ff <= PH_DONE;
        end
        PH_DONE: begin
          phase_ff <= PH_DONE;
        end
        default: begin
          phase_ff <= PH_INSTR;
        end
      endcase
    end
  end

  // Read fetches: first after the instruction, then one per outgoing word except the last
  assign post_first = word_done && (phase_ff == PH_INSTR) && (nxt_shift[DIR_BIT] == DIR_READ);
  assign post_next  = (phase_ff == PH_RDATA) && (bit_cnt_ff == FIRST_BIT) && (remain_ff != REMAIN_ONE)
                      && rd_ready_s;

  // Request toggles survive select; only the system reset clears them
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      rreq_tog_ff  <= 1'b0;
      rreq_addr_ff <= ADDR_RST;
    end else if (post_first) begin
      rreq_tog_ff  <= ~rreq_tog_ff;
      rreq_addr_ff <= nxt_shift[ADDR_W-1:0];
    end else if (post_next) begin
      rreq_tog_ff  <= ~rreq_tog_ff;
      rreq_addr_ff <= step_addr(addr_ff, dec_s);
    end
  end

  // Completed write words cross to the system side; a busy slot loses the word
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      wreq_tog_ff  <= 1'b0;
      wreq_word_ff <= '0;
      ovf_ff       <= 1'b0;
    end else if (word_done && (phase_ff == PH_WDATA)) begin
      if (wr_pend_s) begin
        ovf_ff <= 1'b1;
      end else begin
        wreq_tog_ff       <= ~wreq_tog_ff;
        wreq_word_ff.addr <= addr_ff;
        wreq_word_ff.data <= nxt_shift;
      end
    end else if (word_done && (phase_ff == PH_INSTR)) begin
      ovf_ff <= 1'b0;
    end
  end

  // Output shifter, driven on the falling edge
  // Word loads on the fall after the 32nd rise, so bit one meets rise 33
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_shift_ff <= WORD_RST;
      sdo_ff      <= 1'b0;
      sdo_en_ff   <= 1'b0;
    end else if (phase_ff == PH_RDATA) begin
      sdo_en_ff <= 1'b1;
      if (bit_cnt_ff == FIRST_BIT) begin
        // Late user data goes out as zeros rather than stale bits
        tx_shift_ff <= rd_ready_s ? rdata_hold_ff : WORD_RST;
        sdo_ff      <= rd_ready_s ? (lsb_s ? rdata_hold_ff[0] : rdata_hold_ff[15]) : 1'b0;
      end else if (lsb_s) begin
        tx_shift_ff <= {1'b0, tx_shift_ff[15:1]};
        sdo_ff      <= tx_shift_ff[1];
      end else begin
        tx_shift_ff <= {tx_shift_ff[14:0], 1'b0};
        sdo_ff      <= tx_shift_ff[14];
      end
    end else begin
      sdo_ff    <= 1'b0;
      sdo_en_ff <= 1'b0;
    end
  end

  assign serial_data_out    = sdo_ff;
  assign serial_data_out_en = sdo_en_ff;

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------

  // Request toggles and the overflow level into the system domain
  hswt_sync #(
    .WIDTH (3)
  ) u_sys_sync (
    .clk (clock),
    .rst (reset),
    .d   ({ovf_ff, wreq_tog_ff, rreq_tog_ff}),
    .q   (sys_sync)
  );

  assign wr_overflow = sys_sync[2];
  assign wreq_s      = sys_sync[1];
  assign rreq_s      = sys_sync[0];

  // User read: hold the request until data arrives, then acknowledge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_state_ff   <= RD_IDLE;
      rd_req_ff     <= 1'b0;
      rd_addr_ff    <= ADDR_RST;
      rdata_hold_ff <= WORD_RST;
      rack_tog_ff   <= 1'b0;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          // Address is stable: the serial side waits for the acknowledge
          if (rreq_s != rack_tog_ff) begin
            rd_req_ff   <= 1'b1;
            rd_addr_ff  <= rreq_addr_ff;
            rd_state_ff <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (rd_valid) begin
            rd_req_ff     <= 1'b0;
            rdata_hold_ff <= rd_data;
            rack_tog_ff   <= ~rack_tog_ff;
            rd_state_ff   <= RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= RD_IDLE;
        end
      endcase
    end
  end

  assign rd_req  = rd_req_ff;
  assign rd_addr = rd_addr_ff;

  // A pending write enters the FIFO only when it has room
  assign fifo_in_valid = (wreq_s != wack_tog_ff);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wack_tog_ff <= 1'b0;
    end else if (fifo_in_valid && fifo_in_ready) begin
      wack_tog_ff <= ~wack_tog_ff;
    end
  end

  // Write buffer between the serial port and the user
  hswt_fifo #(
    .WIDTH (WR_WORD_W),
    .DEPTH (FIFO_D)
  ) u_wr_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wreq_word_ff),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Output register so the user sees flops; refills while the user takes
  assign fifo_out_ready = !wr_valid_ff || wr_ready;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_valid_ff <= 1'b0;
      wr_word_ff  <= '0;
    end else if (fifo_out_ready) begin
      wr_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) wr_word_ff <= hswt_wr_word_type'(fifo_out_data);
    end
  end

  assign wr_valid = wr_valid_ff;
  assign wr_word  = wr_word_ff;

endmodule // hswt_top

`default_nettype wire

// >>> verification/hswt_host.sv
// Partner model: host controller framing words on the serial port
`default_nettype none

module hswt_host (
  output logic      sclk, // Serial clock, still outside frames
  output logic      cs_n, // Select, active low
  output logic      sdi,  // Data to the port
  input  wire logic sdo,  // Data from the port
  input  wire logic lsb   // Bit order in use
);
  timeunit 1ns;
  timeprecision 100ps;

  realtime half = 6.0; // Half of the 12 ns serial period

  // Idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Odd offset keeps serial edges off the system clock edges
  task automatic open_frame();
    #(1.3);
    cs_n = 1'b0;
    #(half);
  endtask

  // Data set while the clock is low, answer read on the rise
  task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
    int idx;
    r = 16'h0000;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : 15 - i;
      sdi = w[idx];
      #(half);
      sclk = 1'b1;
      r[idx] = sdo;
      #(half);
      sclk = 1'b0;
    end
  endtask

  // Select lifted half a period after the last clock fall; data line stops holding
  task automatic close_frame();
    #(half);
    cs_n = 1'b1;
    sdi = ~sdi;
    #(2 * half);
  endtask
endmodule // hswt_host

`default_nettype wire

// >>> verification/hswt_properties.sv
// Checker: framing and handshake properties of the serial word port
`default_nettype none

module hswt_properties
  import hswt_pkg::*;
(
  input wire logic                       clock,              // System clock
  input wire logic                       reset,              // Async reset
  input wire logic                       sclk,               // Serial clock
  input wire logic                       cs_n,               // Select, active low
  input wire logic                       serial_data_out,    // Read data
  input wire logic                       serial_data_out_en, // Read drive
  input wire logic                       wr_valid,           // Write offered
  input wire logic                       wr_ready,           // Write taken
  input wire hswt_pkg::hswt_wr_word_type wr_word,            // Write carrier
  input wire logic                       rd_req,             // Read request
  input wire logic                [14:0] rd_addr,            // Read address
  input wire logic                       rd_valid            // Read answer
);
  logic [7:0] bit_cnt_ff; // Rises since select fell

  // Own bit count, cleared by select so aborted frames cannot skew it
  always_ff @(posedge sclk or posedge cs_n or posedge reset) begin
    if (reset || cs_n) begin
      bit_cnt_ff <= 8'h00;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
    end
  end

  // Read handshake steps
  sequence s_rd_pending;
    rd_req && !rd_valid;
  endsequence
  sequence s_rd_taken;
    rd_req && rd_valid;
  endsequence

  property p_idle_quiet;
    @(posedge clock) disable iff (reset) cs_n |-> !serial_data_out_en && !serial_data_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("data driven while deselected");
  property p_off_zero;
    @(posedge clock) disable iff (reset) !serial_data_out_en |-> !serial_data_out;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("data not zero outside read words");
  property p_on_fall;
    @(posedge clock) disable iff (reset)
      $changed(serial_data_out) || $changed(serial_data_out_en) |-> !sclk;
  endproperty
  a_on_fall: assert property (p_on_fall)
    else $error("output changed while serial clock high");
  property p_first_bit;
    @(negedge sclk) disable iff (reset || cs_n) $rose(serial_data_out_en) |-> bit_cnt_ff == 8'h21;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("read data did not start at bit 33");
  property p_whole_word;
    @(negedge sclk) disable iff (reset || cs_n) $fell(serial_data_out_en) |-> bit_cnt_ff[3:0] == 4'h1;
  endproperty
  a_whole_word: assert property (p_whole_word)
    else $error("read drive ended inside a word");
  property p_rd_hold;
    @(posedge clock) disable iff (reset) s_rd_pending |=> rd_req && $stable(rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read request moved before answer");
  property p_rd_release;
    @(posedge clock) disable iff (reset) s_rd_taken |=> !rd_req;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("read request held after answer");
  property p_wr_hold;
    @(posedge clock) disable iff (reset) wr_valid && !wr_ready |=> wr_valid && $stable(wr_word);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write offer changed before taken");
endmodule // hswt_properties

bind hswt_top hswt_properties u_props (.clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n),
  .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_word(wr_word), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid));

`default_nettype wire

// >>> verification/hswt_top_test.sv
// Testbench: host frames against the serial word port with user-side responders
`default_nettype none

module hswt_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import hswt_pkg::*;

  logic             clock = 1'b0, reset = 1'b1, lsb_first = 1'b0, addr_decrement = 1'b0;
  logic             wr_ready = 1'b0, rd_valid = 1'b0, stall = 1'b0;
  logic      [15:0] rd_data = 16'h0000;
  wire logic        sclk, cs_n, sdi, sdo, sdo_en, wr_valid, rd_req, wr_overflow;
  wire logic [14:0] rd_addr;
  hswt_wr_word_type wr_word;
  hswt_wr_word_type wq[$];
  int               bad_count = 0, checks_done = 0;

  always #2.5 clock = ~clock;

  hswt_top dut (.clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n), .serial_data_in(sdi),
    .lsb_first(lsb_first), .addr_decrement(addr_decrement), .serial_data_out(sdo),
    .serial_data_out_en(sdo_en), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_overflow(wr_overflow));
  hswt_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .lsb(lsb_first));

  function automatic logic [15:0] val(input logic [14:0] a);
    return {a[7:0], ~a[7:0]};
  endfunction
  function automatic logic [15:0] dat(input int i);
    return 16'hc3a1 + 16'(i) * 16'h0101;
  endfunction

  // User side: answer reads a cycle late, take writes unless stalled
  always @(posedge clock) begin
    rd_valid <= rd_req && !rd_valid;
    rd_data  <= val(rd_addr);
    wr_ready <= !stall;
    if (wr_valid && wr_ready) begin
      wq.push_back(wr_word);
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_wr(input hswt_wr_word_type got, input hswt_wr_word_type exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t write word: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  // Config changes only while deselected
  task automatic set_cfg(input logic lsb, input logic dec);
    @(posedge clock);
    lsb_first <= lsb;
    addr_decrement <= dec;
    repeat (2) @(posedge clock);
  endtask

  // Streamed write of n words, address stepping with wrap
  task automatic t_write(input logic [14:0] a, input int n, input logic dec, input logic lsb);
    logic [15:0] r;
    hswt_wr_word_type e;
    set_cfg(lsb, dec);
    wq.delete();
    host.open_frame();
    host.shift({DIR_WRITE, a}, 16, r);
    for (int i = 0; i < n; i++) host.shift(dat(i), 16, r);
    host.close_frame();
    for (int k = 0; k < 300 && wq.size() < n; k++) @(posedge clock);
    repeat (10) @(posedge clock);
    chk_word(16'(wq.size()), 16'(n), "write count");
    for (int i = 0; i < n; i++) begin
      e.addr = dec ? a - 15'(i) : a + 15'(i);
      e.data = dat(i);
      chk_wr(wq[i], e);
    end
    $display("t_write %h finished", a);
  endtask

  // Read of cnt words; one more word must come back blank
  task automatic t_read(input logic [14:0] a, input logic [15:0] cnt, input logic lsb, input logic dec);
    logic [15:0] r;
    logic [14:0] e;
    int n;
    n = (cnt == 16'h0000) ? 1 : int'(cnt);
    set_cfg(lsb, dec);
    host.open_frame();
    host.shift({DIR_READ, a}, 16, r);
    host.shift(cnt, 16, r);
    for (int i = 0; i <= n; i++) begin
      host.shift(16'h0000, 16, r);
      e = dec ? a - 15'(i) : a + 15'(i);
      chk_word(r, (i < n) ? val(e) : 16'h0000, "read data");
    end
    host.close_frame();
    repeat (10) @(posedge clock);
    $display("t_read %h finished", a);
  endtask

  // Select lifted mid-word: nothing may land until a whole new frame
  task automatic t_abort();
    logic [15:0] r;
    set_cfg(1'b0, 1'b0);
    wq.delete();
    host.open_frame();
    host.shift({DIR_WRITE, 15'h0100}, 16, r);
    host.shift(16'hdead, 9, r);
    host.close_frame();
    host.open_frame();
    host.shift({DIR_WRITE, 15'h0300}, 7, r);
    host.close_frame();
    repeat (20) @(posedge clock);
    chk_word(16'(wq.size()), 16'h0000, "aborted words");
    t_write(15'h0200, 1, 1'b0, 1'b0);
    $display("t_abort finished");
  endtask

  // Drain stalled: fill until refused, then drain in order
  task automatic t_flood();
    logic [15:0] r;
    hswt_wr_word_type e;
    set_cfg(1'b0, 1'b0);
    wq.delete();
    stall <= 1'b1;
    host.open_frame();
    host.shift({DIR_WRITE, 15'h0040}, 16, r);
    for (int i = 0; i < 8; i++) host.shift(dat(i), 16, r);
    host.close_frame();
    repeat (8) @(posedge clock);
    chk_bit(wr_overflow, 1'b1, "overflow flag");
    chk_bit(wr_valid, 1'b1, "held offer");
    stall <= 1'b0;
    repeat (40) @(posedge clock);
    chk_bit(wq.size() >= FIFO_DEPTH && wq.size() < 8, 1'b1, "kept words");
    for (int i = 0; i < wq.size(); i++) begin
      e.addr = 15'h0040 + 15'(i);
      e.data = dat(i);
      chk_wr(wq[i], e);
    end
    t_write(15'h0050, 2, 1'b0, 1'b0);
    chk_bit(wr_overflow, 1'b0, "overflow cleared");
    $display("t_flood finished");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_write(15'h7ffe, 3, 1'b0, 1'b0);
    t_write(15'h0001, 3, 1'b1, 1'b1);
    t_read(15'h0010, 16'h0000, 1'b0, 1'b0);
    t_read(15'h0020, 16'h0001, 1'b1, 1'b0);
    t_read(15'h7ffe, 16'h0003, 1'b0, 1'b0);
    t_read(15'h0001, 16'h0002, 1'b0, 1'b1);
    t_abort();
    t_flood();
    print_verdict();
  end

  // Watchdog well beyond the expected run of some 10 us
  initial begin
    #100000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // hswt_top_test

`default_nettype wire
